// ---- logic/swsl_host.sv ----
/*
  Single-wire bus master: reset/presence, byte write and read slots, CRC16
  tracking and a two-entry receive buffer.
  Assumes an external pull-up on the line and inputs synchronous to sys_clk_i.
*/
// Overview of operation
// - Reset low lasts 480 us regular or 48 us fast, then release and listen.
// - Four signal types; master starts all but presence.
// - Every bit slot begins with the master driving the line low.
// - Reset low plus rise time stays below 960 us.
// - Write memory 55h: address low, high, data; CRC16 then echo returned.
// - Convert 3Ch: mask and control byte, then CRC16 over all three.
// - After convert CRC, read until device returns FFh.
// - Read memory AAh: address low, high; data then CRC16 returned.
// - Skip-selection CCh after presence reaches memory and convert functions.
`timescale 1ns/1ps

module swsl_host
  import swsl_pkg::*;
#(
  parameter int RST_LOW_STD_CYC  = RESET_LOW_STD_CYC,
  parameter int RST_LOW_FAST_CYC = RESET_LOW_FAST_CYC,
  parameter int PRES_SMP_STD_CYC = PRES_SAMPLE_STD_CYC,
  parameter int PRES_END_CYC     = PRES_END_STD_CYC,
  parameter int SLOT_LEN_CYC     = SLOT_STD_CYC,
  parameter int W0_LEN_CYC       = W0_LOW_STD_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire swsl_op_type cmd_op_i,
  input  wire logic        cmd_fast_i,
  input  wire logic [7:0]  cmd_data_i,
  input  wire logic [15:0] crc_seed_i,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  output logic [7:0]       rx_data_o,
  output logic             done_o,
  output logic             presence_o,
  output logic             fast_speed_flag_o,
  output logic             convert_done_o,
  output logic             high_alarm_flag_o,
  output logic             low_alarm_flag_o,
  output logic [15:0]      crc_o,
  output logic             crc_ok_o,
  input  wire logic        line_i,
  output logic             line_o,
  output logic             line_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic [1:0]      rst_sync_q;
  logic            rst_n;
  swsl_state_type  state_q;
  swsl_op_type     op_q;
  logic            cmd_ready_q, done_q, oe_q, fast_q, presence_q;
  logic [T_W-1:0]  t_q;
  logic [2:0]      bit_q;
  logic [7:0]      sh_q;
  logic [15:0]     crc_q;
  logic            crc_ok_q, conv_q, alarm_hi_q, alarm_lo_q;
  logic [7:0]      rx_data_q, spare_q;
  logic            rx_valid_q, spare_v_q;
  logic            accept, push, pop, is_write, crc_step, crc_bit;
  logic [15:0]     crc_d;
  logic [T_W-1:0]  rst_low_c, pres_c, rst_end_c, low_c, rd_c, slot_c;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Timing selection by speed
  assign accept   = cmd_valid_i && cmd_ready_q;
  assign is_write = (op_q == OP_WRITE);
  always_comb begin
    rst_low_c = fast_q ? T_W'(RST_LOW_FAST_CYC) : T_W'(RST_LOW_STD_CYC);
    pres_c    = rst_low_c + (fast_q ? T_W'(PRES_SAMPLE_FAST_CYC) : T_W'(PRES_SMP_STD_CYC));
    rst_end_c = rst_low_c + (fast_q ? T_W'(PRES_END_FAST_CYC) : T_W'(PRES_END_CYC));
    rd_c      = fast_q ? T_W'(RD_SAMPLE_FAST_CYC) : T_W'(RD_SAMPLE_STD_CYC);
    slot_c    = fast_q ? T_W'(SLOT_FAST_CYC) : T_W'(SLOT_LEN_CYC);
    if (is_write && !sh_q[0]) begin
      low_c = fast_q ? T_W'(W0_LOW_FAST_CYC) : T_W'(W0_LEN_CYC);
    end else begin
      low_c = fast_q ? T_W'(W1_LOW_FAST_CYC) : T_W'(W1_LOW_STD_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: reset/presence and bit slots
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_RESET;
      cmd_ready_q <= 1'b0;
      done_q      <= 1'b0;
      oe_q        <= 1'b0;
      t_q         <= '0;
      bit_q       <= 3'h0;
      sh_q        <= 8'h00;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (accept) begin
            cmd_ready_q <= 1'b0;
            op_q        <= cmd_op_i;
            sh_q        <= cmd_data_i;
            bit_q       <= 3'h0;
            t_q         <= T_W'(1);
            case (cmd_op_i)
              OP_RESET: begin
                oe_q    <= 1'b1;
                state_q <= ST_RST_LOW;
              end
              OP_WRITE, OP_READ, OP_READ_STATUS: begin
                oe_q    <= 1'b1;
                state_q <= ST_SLOT;
              end
              default: begin
                done_q      <= 1'b1;
                cmd_ready_q <= 1'b1;
              end
            endcase
          end
        end
        ST_RST_LOW: begin
          t_q <= t_q + T_W'(1);
          if (t_q == rst_low_c) begin
            oe_q    <= 1'b0;
            state_q <= ST_RST_WAIT;
          end
        end
        ST_RST_WAIT: begin
          t_q <= t_q + T_W'(1);
          if (t_q == pres_c) begin
            state_q <= ST_RST_REC;
          end
        end
        ST_RST_REC: begin
          t_q <= t_q + T_W'(1);
          if (t_q >= rst_end_c) begin
            done_q      <= 1'b1;
            cmd_ready_q <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        ST_SLOT: begin
          t_q <= t_q + T_W'(1);
          if (t_q == low_c) begin
            oe_q <= 1'b0;
          end
          if (!is_write && t_q == rd_c) begin
            sh_q <= {line_i, sh_q[7:1]};
          end
          if (t_q == slot_c) begin
            if (is_write) begin
              sh_q <= {1'b0, sh_q[7:1]};
            end
            if (bit_q == 3'h7) begin
              if (is_write) begin
                done_q      <= 1'b1;
                cmd_ready_q <= 1'b1;
                state_q     <= ST_IDLE;
              end else begin
                state_q <= ST_PUSH;
              end
            end else begin
              bit_q <= bit_q + 3'h1;
              t_q   <= T_W'(1);
              oe_q  <= 1'b1;
            end
          end
        end
        ST_PUSH: begin
          if (push) begin
            done_q      <= 1'b1;
            cmd_ready_q <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed flag and presence
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fast_q <= 1'b0;
    end else if (accept && cmd_op_i == OP_SET_FAST) begin
      fast_q <= 1'b1;
    end else if (accept && cmd_op_i == OP_RESET) begin
      fast_q <= fast_q && cmd_fast_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presence_q <= 1'b0;
    end else if (state_q == ST_RST_WAIT && t_q == pres_c) begin
      presence_q <= !line_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC16 over every bit sent or received
  assign crc_step = (state_q == ST_SLOT) && (is_write ? (t_q == T_W'(1)) : (t_q == rd_c));
  assign crc_bit  = is_write ? sh_q[0] : line_i;
  always_comb begin
    crc_d = {1'b0, crc_q[15:1]};
    if (crc_q[0] ^ crc_bit) begin
      crc_d = crc_d ^ CRC_POLY_REFL;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      crc_q    <= 16'h0000;
      crc_ok_q <= 1'b0;
    end else if (accept && cmd_op_i == OP_CRC_LOAD) begin
      crc_q    <= crc_seed_i;
      crc_ok_q <= 1'b0;
    end else if (crc_step) begin
      crc_q    <= crc_d;
      crc_ok_q <= (crc_d == CRC_RESIDUE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry receive buffer and decoded results
  assign push = (state_q == ST_PUSH) && !spare_v_q;
  assign pop  = rx_valid_q && rx_ready_i;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_q  <= 8'h00;
      rx_valid_q <= 1'b0;
      spare_q    <= 8'h00;
      spare_v_q  <= 1'b0;
    end else if (push) begin
      if (!rx_valid_q || pop) begin
        rx_data_q  <= sh_q;
        rx_valid_q <= 1'b1;
      end else begin
        spare_q   <= sh_q;
        spare_v_q <= 1'b1;
      end
    end else if (pop) begin
      if (spare_v_q) begin
        rx_data_q <= spare_q;
        spare_v_q <= 1'b0;
      end else begin
        rx_valid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conv_q     <= 1'b0;
      alarm_hi_q <= 1'b0;
      alarm_lo_q <= 1'b0;
    end else begin
      conv_q <= push && (sh_q == CONVERT_DONE_BYTE);
      if (push && op_q == OP_READ_STATUS) begin
        alarm_hi_q <= sh_q[HIGH_ALARM_BIT];
        alarm_lo_q <= sh_q[LOW_ALARM_BIT];
      end
    end
  end

  assign cmd_ready_o       = cmd_ready_q;
  assign rx_valid_o        = rx_valid_q;
  assign rx_data_o         = rx_data_q;
  assign done_o            = done_q;
  assign presence_o        = presence_q;
  assign fast_speed_flag_o = fast_q;
  assign convert_done_o    = conv_q;
  assign high_alarm_flag_o = alarm_hi_q;
  assign low_alarm_flag_o  = alarm_lo_q;
  assign crc_o             = crc_q;
  assign crc_ok_o          = crc_ok_q;
  assign line_oe_o         = oe_q;
  assign line_o            = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [T_W-1:0] low_run_q;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      low_run_q <= '0;
    end else begin
      low_run_q <= oe_q ? low_run_q + T_W'(1) : '0;
    end
  end

  chk_reset_low_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    $fell(oe_q) && state_q == ST_RST_WAIT |-> low_run_q == rst_low_c)
    else $error("reset low time wrong");
  chk_reset_below_max: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    oe_q |-> low_run_q < T_W'(RESET_LOW_MAX_CYC))
    else $error("line held low too long");
  chk_regular_reset_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    accept && cmd_op_i == OP_RESET && !cmd_fast_i |=> !fast_q)
    else $error("regular reset left fast speed");
  chk_fast_reset_short: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    $fell(oe_q) && state_q == ST_RST_WAIT && fast_q |-> low_run_q <= T_W'(RESET_FAST_KEEP_CYC))
    else $error("fast reset too long");
  chk_slot_starts_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    $rose(oe_q) |-> state_q == ST_RST_LOW || state_q == ST_SLOT)
    else $error("line driven low outside a slot or reset");
  chk_write_bit_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    $fell(oe_q) && state_q == ST_SLOT && is_write |->
      low_run_q == (sh_q[0] ? (fast_q ? T_W'(W1_LOW_FAST_CYC) : T_W'(W1_LOW_STD_CYC))
                            : (fast_q ? T_W'(W0_LOW_FAST_CYC) : T_W'(W0_LEN_CYC))))
    else $error("write slot low time does not match bit");
  chk_presence_sample: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    state_q == ST_RST_WAIT && t_q == pres_c |=> presence_q == !$past(line_i))
    else $error("presence not sampled");
  chk_convert_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    conv_q |-> $past(push) && $past(sh_q) == CONVERT_DONE_BYTE)
    else $error("convert done without FFh byte");

endmodule : swsl_host

// ---- logic/swsl_pkg.sv ----
/*
  Constants, timing and types for the single-wire bus master.
  Assumes a 125 MHz system clock; times are in ns, counts in clock cycles.
*/
package swsl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_NS = 8;
  localparam int T_W    = 17;

  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_up

  localparam int RESET_LOW_TIME_STD_NS    = 480000;
  localparam int RESET_LOW_TIME_FAST_NS   = 48000;
  localparam int RESET_LOW_MAX_NS         = 960000;
  localparam int RESET_FAST_KEEP_MAX_NS   = 80000;
  localparam int PRESENCE_WAIT_TIME_STD_NS  = 60000;
  localparam int PRESENCE_WAIT_TIME_FAST_NS = 6000;
  localparam int PRESENCE_LOW_MIN_STD_NS  = 60000;
  localparam int PRESENCE_LOW_MIN_FAST_NS = 8000;
  localparam int PRESENCE_LOW_MAX_STD_NS  = 240000;
  localparam int PRESENCE_LOW_MAX_FAST_NS = 24000;
  localparam int SLOT_STD_NS     = 70000;
  localparam int SLOT_FAST_NS    = 10000;
  localparam int W0_LOW_STD_NS   = 60000;
  localparam int W0_LOW_FAST_NS  = 8000;
  localparam int W1_LOW_STD_NS   = 6000;
  localparam int W1_LOW_FAST_NS  = 1000;
  localparam int RD_SAMPLE_STD_NS  = 12000;
  localparam int RD_SAMPLE_FAST_NS = 2000;

  // Presence sampled mid-way through its guaranteed low time
  localparam int PRES_SAMPLE_STD_NS  = PRESENCE_WAIT_TIME_STD_NS + PRESENCE_LOW_MIN_STD_NS / 2;
  localparam int PRES_SAMPLE_FAST_NS = PRESENCE_WAIT_TIME_FAST_NS + PRESENCE_LOW_MIN_FAST_NS / 2;
  localparam int PRES_END_STD_NS  = PRESENCE_WAIT_TIME_STD_NS + PRESENCE_LOW_MAX_STD_NS;
  localparam int PRES_END_FAST_NS = PRESENCE_WAIT_TIME_FAST_NS + PRESENCE_LOW_MAX_FAST_NS;

  localparam int RESET_LOW_STD_CYC   = cyc_up(RESET_LOW_TIME_STD_NS);
  localparam int RESET_LOW_FAST_CYC  = cyc_up(RESET_LOW_TIME_FAST_NS);
  localparam int RESET_LOW_MAX_CYC   = RESET_LOW_MAX_NS / CLK_NS;
  localparam int RESET_FAST_KEEP_CYC = RESET_FAST_KEEP_MAX_NS / CLK_NS;
  localparam int PRES_SAMPLE_STD_CYC  = cyc_up(PRES_SAMPLE_STD_NS);
  localparam int PRES_SAMPLE_FAST_CYC = cyc_up(PRES_SAMPLE_FAST_NS);
  localparam int PRES_END_STD_CYC  = cyc_up(PRES_END_STD_NS);
  localparam int PRES_END_FAST_CYC = cyc_up(PRES_END_FAST_NS);
  localparam int SLOT_STD_CYC     = cyc_up(SLOT_STD_NS);
  localparam int SLOT_FAST_CYC    = cyc_up(SLOT_FAST_NS);
  localparam int W0_LOW_STD_CYC   = cyc_up(W0_LOW_STD_NS);
  localparam int W0_LOW_FAST_CYC  = cyc_up(W0_LOW_FAST_NS);
  localparam int W1_LOW_STD_CYC   = cyc_up(W1_LOW_STD_NS);
  localparam int W1_LOW_FAST_CYC  = cyc_up(W1_LOW_FAST_NS);
  localparam int RD_SAMPLE_STD_CYC  = cyc_up(RD_SAMPLE_STD_NS);
  localparam int RD_SAMPLE_FAST_CYC = cyc_up(RD_SAMPLE_FAST_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Device command bytes, addresses and values
  localparam logic [7:0]  CMD_SKIP_SELECT   = 8'hCC;
  localparam logic [7:0]  CMD_WRITE_MEMORY  = 8'h55;
  localparam logic [7:0]  CMD_CONVERT       = 8'h3C;
  localparam logic [7:0]  CMD_READ_MEMORY   = 8'hAA;
  localparam logic [7:0]  CONVERT_DONE_BYTE = 8'hFF;
  localparam logic [15:0] ADDR_CH4_STATUS   = 16'h000F;
  localparam logic [15:0] ADDR_CH4_ALARM_LO = 16'h0016;
  localparam logic [15:0] ADDR_CH4_ALARM_HI = 16'h0017;
  localparam logic [15:0] ADDR_CH1_CONTROL  = 16'h0008;
  localparam logic [15:0] ADDR_CH2_CONTROL  = 16'h000A;
  localparam logic [7:0]  OUTPUT_ON_BYTE    = 8'h80;
  localparam logic [7:0]  OUTPUT_OFF_BYTE   = 8'hC0;
  localparam int          LOW_ALARM_BIT     = 4;
  localparam int          HIGH_ALARM_BIT    = 5;

  // CRC16, reflected form of x16+x15+x2+1
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE   = 16'hB001;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    OP_RESET, OP_WRITE, OP_READ, OP_READ_STATUS, OP_SET_FAST, OP_CRC_LOAD
  } swsl_op_type;

  typedef enum {
    ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_RST_REC, ST_SLOT, ST_PUSH
  } swsl_state_type;

endpackage : swsl_pkg

// ---- tb/swsl_dev_model.sv ----
/*
  Behavioural single-wire slave: reset/presence, bit slots, skip commands, read and write memory.
  Assumes the bench resolves the open-drain line with a pull-up; timing is scaled to the bench.
*/
`timescale 1ns/1ps

module swsl_dev_model
  import swsl_pkg::*;
#(
  parameter int RST_MIN_CYC = 1560,
  parameter int FAST_EXIT_CYC = 3000
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic alarm_hi_i,
  input  wire logic alarm_lo_i,
  output logic      pull_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic        fast_q;
  logic [7:0]  mem [0:31];
  logic        txb[$];
  logic [7:0]  rxb;
  logic [15:0] crc;
  logic [15:0] adr;
  logic [7:0]  d;
  logic        v;
  int          rxn;
  int          ph;
  int          n;

  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc_b

  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      txb.push_back(b[i]);
    end
  endtask : put

  task automatic take_byte(input logic [7:0] b);
    if (ph == 0) begin
      fast_q = fast_q | (b == 8'h3C);
      ph = (b == 8'hCC || b == 8'h3C) ? 1 : 9;
    end else if (ph == 1) begin
      crc = crc_b(16'h0000, b);
      ph = (b == 8'hAA) ? 2 : ((b == 8'h55) ? 5 : 9);
    end else if (ph == 7) begin
      // Write memory data byte: CRC, then echo of the stored byte
      crc = crc_b(crc, b);
      mem[adr[4:0]] = b;
      put(~crc[7:0]);
      put(~crc[15:8]);
      put(mem[adr[4:0]]);
      adr++;
      crc = adr;
    end else if (ph < 4 || ph == 5 || ph == 6) begin
      crc = crc_b(crc, b);
      adr = {b, adr[15:8]};
      ph++;
      if (ph == 4) begin
        do begin
          d = (adr == 16'h000F) ? {2'b00, alarm_hi_i, alarm_lo_i, 4'h0} : adr[7:0];
          crc = crc_b(crc, d);
          put(d);
          adr++;
        end while (adr[2:0] != 3'h0);
        put(~crc[7:0]);
        put(~crc[15:8]);
      end
    end
  endtask : take_byte

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pull_o = 1'b0;
    fast_q = 1'b0;
    ph = 9;
    rxn = 0;
    forever begin
      @(negedge line_i);
      n = 0;
      if (txb.size() > 0) begin
        v = txb.pop_front();
        if (!v) begin
          pull_o = 1'b1;
          n = fast_q ? 600 : 1540;
          repeat (n) @(posedge clk_i);
          pull_o = 1'b0;
        end
      end else begin
        n = fast_q ? 500 : 1000;
        repeat (n) @(posedge clk_i);
        rxb = {line_i, rxb[7:1]};
        rxn++;
        if (rxn == 8) begin
          take_byte(rxb);
          rxn = 0;
        end
      end
      while (line_i === 1'b0) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= RST_MIN_CYC) begin
        fast_q = fast_q && (n < FAST_EXIT_CYC);
        txb.delete();
        rxn = 0;
        ph = 0;
        repeat (fast_q ? 500 : 10) @(posedge clk_i);
        pull_o = 1'b1;
        repeat (fast_q ? 2000 : 40) @(posedge clk_i);
        pull_o = 1'b0;
      end
    end
  end

endmodule : swsl_dev_model

// ---- tb/tb_swsl_host.sv ----
/*
  Self-checking bench for the single-wire bus master against a behavioural slave.
  Assumes swsl_dev_model and shortened reset and slot parameters.
*/
`timescale 1ns/1ps

module tb_swsl_host
  import swsl_pkg::*;
();
  localparam int RST_STD = 4000;
  localparam int RST_FST = 2000;
  localparam int LIM     = 13500;

  logic        clk, rst_n, cmd_valid, cmd_ready, cmd_fast, rx_valid, rx_ready, done;
  logic        presence, fast_flag, hi_flag, lo_flag, crc_ok, line_oe, dev_pull;
  logic        conv_done, alarm_hi, alarm_lo;
  logic [15:0] crc_val, crc_seed;
  logic [7:0]  cmd_data, rx_data;
  swsl_op_type cmd_op;
  wire         line = ~(line_oe | dev_pull);
  int          n_errors = 0;
  int          n_tests = 0;
  int          oe_cnt = 0;
  int          oe_len = 0;

  swsl_host #(.RST_LOW_STD_CYC(RST_STD), .RST_LOW_FAST_CYC(RST_FST), .PRES_SMP_STD_CYC(30),
    .PRES_END_CYC(60), .SLOT_LEN_CYC(1600), .W0_LEN_CYC(1200)) i_dut (
    .sys_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_op_i(cmd_op), .cmd_fast_i(cmd_fast), .cmd_data_i(cmd_data), .crc_seed_i(crc_seed),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data), .done_o(done),
    .presence_o(presence), .fast_speed_flag_o(fast_flag), .convert_done_o(conv_done),
    .high_alarm_flag_o(hi_flag), .low_alarm_flag_o(lo_flag), .crc_o(crc_val), .crc_ok_o(crc_ok),
    .line_i(line), .line_o(), .line_oe_o(line_oe));

  swsl_dev_model i_dev (.clk_i(clk), .line_i(line), .alarm_hi_i(alarm_hi), .alarm_lo_i(alarm_lo),
    .pull_o(dev_pull));

  // Length of the last low pulse driven by the master
  always @(posedge clk) begin
    if (line_oe === 1'b1) begin
      oe_cnt <= oe_cnt + 1;
    end else if (oe_cnt != 0) begin
      oe_len <= oe_cnt;
      oe_cnt <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_done(input int lim, output logic seen);
    int k;
    k = 0;
    seen = 1'b0;
    while (!seen && k < lim) begin
      @(posedge clk);
      seen = (done === 1'b1);
      k++;
    end
  endtask : wait_done

  task automatic issue(input swsl_op_type op, input logic [7:0] d, input logic f);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_fast <= f;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask : issue

  task automatic run_cmd(input swsl_op_type op, input logic [7:0] d, input logic f);
    logic seen;
    issue(op, d, f);
    wait_done(LIM, seen);
    chk("done", 16'h0001, {15'h0, seen});
  endtask : run_cmd

  task automatic pop(input logic [7:0] exp);
    int k;
    k = 0;
    rx_ready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rx_valid !== 1'b1 && k < 50);
    chk("rx_valid_data", {7'h0, 1'b1, exp}, {7'h0, rx_valid, rx_data});
    rx_ready <= 1'b0;
    @(posedge clk);
  endtask : pop

  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_std();
    run_cmd(OP_RESET, 8'h00, 1'b0);
    chk("reset_low", 16'(RST_STD), oe_len[15:0]);
    chk("presence", 16'h0001, {15'h0, presence});
    chk("fast_flag", 16'h0000, {15'h0, fast_flag});
  endtask : test_reset_std

  task automatic test_fast_read();
    logic [15:0] c;
    logic        seen;
    run_cmd(OP_WRITE, 8'h3C, 1'b0);
    run_cmd(OP_SET_FAST, 8'h00, 1'b0);
    chk("fast_flag", 16'h0001, {15'h0, fast_flag});
    crc_seed <= 16'h5A3C;
    run_cmd(OP_CRC_LOAD, 8'h00, 1'b0);
    chk("crc_seed", 16'h5A3C, crc_val);
    crc_seed <= 16'h0000;
    run_cmd(OP_CRC_LOAD, 8'h00, 1'b0);
    run_cmd(OP_WRITE, 8'hAA, 1'b0);
    run_cmd(OP_WRITE, 8'h0F, 1'b0);
    run_cmd(OP_WRITE, 8'h00, 1'b0);
    run_cmd(OP_READ_STATUS, 8'h00, 1'b0);
    chk("convert_done", 16'h0000, {15'h0, conv_done});
    chk("alarm_flags", 16'h0002, {14'h0, hi_flag, lo_flag});
    run_cmd(OP_READ, 8'h00, 1'b0);
    issue(OP_READ, 8'h00, 1'b0);
    wait_done(10300, seen);
    chk("stalled_done", 16'h0000, {15'h0, seen});
    pop(8'h20);
    wait_done(20, seen);
    chk("done_after_pop", 16'h0001, {15'h0, seen});
    c = i_dev.crc_b(i_dev.crc_b(i_dev.crc_b(i_dev.crc_b(16'h0000, 8'hAA), 8'h0F), 8'h00), 8'h20);
    pop(~c[7:0]);
    pop(~c[15:8]);
    chk("crc_ok", 16'h0001, {15'h0, crc_ok});
    chk("crc_residue", CRC_RESIDUE, crc_val);
    // Nothing left to send: the released line reads back as all ones
    issue(OP_READ, 8'h00, 1'b0);
    wait_done(LIM, seen);
    chk("convert_done", 16'h0001, {15'h0, seen && conv_done});
    pop(CONVERT_DONE_BYTE);
  endtask : test_fast_read

  task automatic test_fast_reset();
    run_cmd(OP_RESET, 8'h00, 1'b1);
    chk("reset_low", 16'(RST_FST), oe_len[15:0]);
    chk("presence", 16'h0001, {15'h0, presence});
    chk("fast_flag", 16'h0001, {15'h0, fast_flag});
  endtask : test_fast_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (120000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_RESET;
    cmd_fast = 1'b0;
    cmd_data = 8'h00;
    rx_ready = 1'b0;
    alarm_hi = 1'b1;
    alarm_lo = 1'b0;
    crc_seed = 16'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_std();
    test_fast_read();
    test_fast_reset();
    test_reset_std();
    report_and_stop();
  end

endmodule : tb_swsl_host
